// ### verilog/dpdm_pkg.sv
// constants shared by the dual-port dac input mux
`default_nettype none

package dpdm_pkg;

	// ----------------------------------------------------------------
	// data path
	// ----------------------------------------------------------------
	localparam int         DATA_WIDTH = 10;
	localparam logic [9:0] CODE_MAX   = 10'h3ff;
	localparam logic [9:0] CODE_RESET = 10'h000;
	localparam int         DATA_MSB   = 9;

	// ----------------------------------------------------------------
	// input mux modes, encoded as {mode_select_high, mode_select_low}
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		DPDM_MODE_INTERLEAVED = 2'b00,
		DPDM_MODE_PORT1       = 2'b01,
		DPDM_MODE_PORT2       = 2'b10,
		DPDM_MODE_INVALID     = 2'b11
	} dpdm_mode_t;

	// ----------------------------------------------------------------
	// reset values and timing counts
	// ----------------------------------------------------------------
	localparam logic       HALF_CLOCK_RESET      = 1'b1;
	localparam logic [1:0] SYNC_RESET            = 2'h0;
	localparam int         OUTPUT_LATENCY_CYCLES = 1;
	localparam int         LOCK_CYCLES           = 16;
	localparam int         LOCK_COUNT_WIDTH      = 5;

endpackage : dpdm_pkg

`default_nettype wire

// ### verilog/dpdm_output_stage.sv
// output latency pipeline and true/complement code generation
`default_nettype none

module dpdm_output_stage #(
	parameter int WIDTH   = dpdm_pkg::DATA_WIDTH,
	parameter int LATENCY = dpdm_pkg::OUTPUT_LATENCY_CYCLES
) (
	input  wire logic             clock,
	input  wire logic             reset,
	input  wire logic [WIDTH-1:0] code,
	input  wire logic             load,
	output logic      [WIDTH-1:0] trueCode,
	output logic      [WIDTH-1:0] complementCode,
	output logic                  update
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [LATENCY-1:0][WIDTH-1:0] truePipe;
		logic [LATENCY-1:0][WIDTH-1:0] compPipe;
		logic [LATENCY-1:0]            loadPipe;
	} dpdm_out_state_t;

	dpdm_out_state_t state_q;
	dpdm_out_state_t state_d;

	// ----------------------------------------------------------------
	// pipeline
	// ----------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		// complement formed up front so both outputs leave from flops
		state_d.truePipe[0] = code;
		state_d.compPipe[0] = dpdm_pkg::CODE_MAX - code;
		state_d.loadPipe[0] = load;
		for (int i = 1; i < LATENCY; i++) begin
			state_d.truePipe[i] = state_q.truePipe[i-1];
			state_d.compPipe[i] = state_q.compPipe[i-1];
			state_d.loadPipe[i] = state_q.loadPipe[i-1];
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	assign trueCode       = state_q.truePipe[LATENCY-1];
	assign complementCode = state_q.compPipe[LATENCY-1];
	assign update         = state_q.loadPipe[LATENCY-1];

endmodule : dpdm_output_stage

`default_nettype wire

// ### verilog/dpdm_input_mux.sv
// dual-port input latches, 1x clock generation and dac latch mux
//
// Behaviour
// - multiplier on: rise latches ports, loads port 2
// - multiplier on: half period later loads port 1
// - strap low disables multiplier; source gives 2x clock
// - multiplier off: mode pair picks interleaved, port 1, port 2
// - interleaved, multiplier off: 2x divided to 1x
// - multiplier off: 1x clock echoed on status pin
// - reset release: 1x high, low, then high
// - early release: first edge drives 1x low
// - single port: latch, then dac next rise
// - straight binary code, true and complement outputs
// - multiplier on: status pin shows lock, high
// - data bit 9 is msb, bit 0 lsb
`default_nettype none

module dpdm_input_mux #(
	parameter int WIDTH       = dpdm_pkg::DATA_WIDTH,
	parameter int LATENCY     = dpdm_pkg::OUTPUT_LATENCY_CYCLES,
	parameter int LOCK_CYCLES = dpdm_pkg::LOCK_CYCLES
) (
	input  wire logic             clock,
	input  wire logic             reset,
	input  wire logic [WIDTH-1:0] port1Data,
	input  wire logic [WIDTH-1:0] port2Data,
	input  wire logic             multiplierSupplyStrap,
	input  wire logic             modeSelectLow,
	input  wire logic             modeSelectHigh,
	input  wire logic             alignReset,
	output logic                  lockOrHalfClockOut,
	output logic      [WIDTH-1:0] trueCurrentOut,
	output logic      [WIDTH-1:0] complementCurrentOut,
	output logic                  dacUpdate,
	output logic                  invalidModeFlag,
	output logic                  multiplierActive
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [1:0]                                strapSync;
		logic [1:0]                                lowSync;
		logic [1:0]                                highSync;
		logic [1:0]                                alignSync;
		logic                                      halfClk;
		logic                                      halfClkEcho;
		logic [WIDTH-1:0]                          port1Latch;
		logic [WIDTH-1:0]                          port2Latch;
		logic [WIDTH-1:0]                          dacLatch;
		logic                                      dacLoad;
		logic                                      invalidFlag;
		logic [dpdm_pkg::LOCK_COUNT_WIDTH-1:0]     lockCount;
		logic                                      locked;
		logic                                      statusPin;
	} dpdm_state_t;

	dpdm_state_t         state_q;
	dpdm_state_t         state_d;
	dpdm_pkg::dpdm_mode_t mode;
	logic                multOn;
	logic                aligning;
	logic                riseEdge;
	logic                fallEdge;

	localparam int LOCK_LAST_INT = LOCK_CYCLES - 1;
	// cut to the counter width on purpose; LOCK_CYCLES - 1 must fit in it
	localparam logic [dpdm_pkg::LOCK_COUNT_WIDTH-1:0] LOCK_LAST =
		LOCK_LAST_INT[dpdm_pkg::LOCK_COUNT_WIDTH-1:0];

	// ----------------------------------------------------------------
	// decoded controls
	// ----------------------------------------------------------------
	always_comb begin
		multOn   = state_q.strapSync[1];
		// alignment reset only matters with the multiplier off
		aligning = state_q.alignSync[1] & ~multOn;
		if (multOn) begin
			mode = dpdm_pkg::DPDM_MODE_INTERLEAVED;
		end else begin
			mode = dpdm_pkg::dpdm_mode_t'({state_q.highSync[1], state_q.lowSync[1]});
		end
		// 1x rises when the divided clock goes from low to high
		riseEdge = ~aligning & ~state_q.halfClk;
		fallEdge = ~aligning & state_q.halfClk;
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		state_d.dacLoad = 1'b0;

		// two flops on every pin-level control
		state_d.strapSync = {state_q.strapSync[0], multiplierSupplyStrap};
		state_d.lowSync   = {state_q.lowSync[0], modeSelectLow};
		state_d.highSync  = {state_q.highSync[0], modeSelectHigh};
		state_d.alignSync = {state_q.alignSync[0], alignReset};

		// ------------------------------------------------------------
		// internal 1x clock
		// ------------------------------------------------------------
		if (aligning) begin
			state_d.halfClk = 1'b1;
		end else begin
			// first edge after release drives it low, next high
			state_d.halfClk = ~state_q.halfClk;
		end
		state_d.halfClkEcho = state_q.halfClk;

		// ------------------------------------------------------------
		// latches and dac mux
		// ------------------------------------------------------------
		case (mode)
			dpdm_pkg::DPDM_MODE_INTERLEAVED: begin
				state_d.invalidFlag = 1'b0;
				if (riseEdge) begin
					// ports held msb at bit 9 straight through
					state_d.port1Latch = port1Data;
					state_d.port2Latch = port2Data;
					state_d.dacLatch   = state_q.port2Latch;
					state_d.dacLoad    = 1'b1;
				end else if (fallEdge) begin
					// half a 1x period later, independent of duty cycle
					state_d.dacLatch = state_q.port1Latch;
					state_d.dacLoad  = 1'b1;
				end
			end
			dpdm_pkg::DPDM_MODE_PORT1: begin
				state_d.invalidFlag = 1'b0;
				if (riseEdge) begin
					state_d.port1Latch = port1Data;
					state_d.dacLatch   = state_q.port1Latch;
					state_d.dacLoad    = 1'b1;
				end
			end
			dpdm_pkg::DPDM_MODE_PORT2: begin
				state_d.invalidFlag = 1'b0;
				if (riseEdge) begin
					state_d.port2Latch = port2Data;
					state_d.dacLatch   = state_q.port2Latch;
					state_d.dacLoad    = 1'b1;
				end
			end
			default: begin
				// dac latch keeps its last code
				state_d.invalidFlag = 1'b1;
			end
		endcase

		// ------------------------------------------------------------
		// lock indication, a simple settle counter
		// ------------------------------------------------------------
		if (!multOn) begin
			state_d.lockCount = '0;
			state_d.locked    = 1'b0;
		end else if (state_q.lockCount == LOCK_LAST) begin
			state_d.locked = 1'b1;
		end else begin
			state_d.lockCount = state_q.lockCount + 1'b1;
		end

		if (multOn) begin
			state_d.statusPin = state_q.locked;
		end else begin
			state_d.statusPin = state_q.halfClkEcho;
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (reset) begin
			state_q             <= '0;
			state_q.halfClk     <= dpdm_pkg::HALF_CLOCK_RESET;
			state_q.halfClkEcho <= dpdm_pkg::HALF_CLOCK_RESET;
			state_q.port1Latch  <= dpdm_pkg::CODE_RESET;
			state_q.port2Latch  <= dpdm_pkg::CODE_RESET;
			state_q.dacLatch    <= dpdm_pkg::CODE_RESET;
			state_q.strapSync   <= dpdm_pkg::SYNC_RESET;
		end else begin
			state_q <= state_d;
		end
	end

	// ----------------------------------------------------------------
	// output latency and current code outputs
	// ----------------------------------------------------------------
	dpdm_output_stage #(
		.WIDTH   (WIDTH),
		.LATENCY (LATENCY)
	) outputStage (
		.clock          (clock),
		.reset          (reset),
		.code           (state_q.dacLatch),
		.load           (state_q.dacLoad),
		.trueCode       (trueCurrentOut),
		.complementCode (complementCurrentOut),
		.update         (dacUpdate)
	);

	assign lockOrHalfClockOut = state_q.statusPin;
	assign invalidModeFlag    = state_q.invalidFlag;
	assign multiplierActive   = state_q.strapSync[1];

endmodule : dpdm_input_mux

`default_nettype wire

// ### sim/dpdm_input_mux_sva.sv
// port assertions for the dac input mux
`default_nettype none
module dpdm_input_mux_sva #(parameter int LOCK_CYCLES = 16) (
	input wire logic       clock,
	input wire logic       reset,
	input wire logic       alignReset,
	input wire logic       lockOrHalfClockOut,
	input wire logic [9:0] trueCurrentOut,
	input wire logic [9:0] complementCurrentOut,
	input wire logic       dacUpdate,
	input wire logic       invalidModeFlag,
	input wire logic       multiplierActive
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] actCnt_q;
	// saturates so a long active spell never wraps
	always_ff @(posedge clock) begin
		if (reset || !multiplierActive) actCnt_q <= 8'h00;
		else if (actCnt_q != 8'hff) actCnt_q <= actCnt_q + 8'h01;
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);
	chk_lock_shown: assert property (
		int'(actCnt_q) > LOCK_CYCLES + 3 |-> lockOrHalfClockOut) else $error("lock low");
	chk_compl_match: assert property (
		dacUpdate |-> complementCurrentOut == 10'h3ff - trueCurrentOut) else $error("compl off");
	chk_output_stands: assert property (
		!dacUpdate |-> $stable(trueCurrentOut)) else $error("code moved");
	chk_full_rate: assert property (
		multiplierActive [*4] |-> dacUpdate) else $error("update missed");
	chk_invalid_hold: assert property (
		invalidModeFlag [*3] |-> !dacUpdate) else $error("update while invalid");
	chk_half_toggle: assert property (
		(!multiplierActive && !alignReset) [*8] |-> lockOrHalfClockOut != $past(lockOrHalfClockOut))
		else $error("half clock stuck");
	chk_align_high: assert property (
		(alignReset && !multiplierActive) [*6] |-> lockOrHalfClockOut) else $error("align low");
	chk_align_release: assert property (
		$fell(alignReset) && !multiplierActive |-> ##[2:7] lockOrHalfClockOut ##1
		!lockOrHalfClockOut ##1 lockOrHalfClockOut) else $error("bad release");
endmodule : dpdm_input_mux_sva
bind dpdm_input_mux dpdm_input_mux_sva #(.LOCK_CYCLES(LOCK_CYCLES)) chk (.clock, .reset,
	.alignReset, .lockOrHalfClockOut, .trueCurrentOut, .complementCurrentOut, .dacUpdate,
	.invalidModeFlag, .multiplierActive);
`default_nettype wire

// ### sim/dpdm_data_source.sv
// data source model driving both ports
`default_nettype none
module dpdm_data_source (
	input  wire logic       clock,
	input  wire logic       multiplierActive,
	input  wire logic       lockOrHalfClockOut,
	output logic      [9:0] port1Data,
	output logic      [9:0] port2Data
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [9:0] expQ[$];
	logic       ph = 1'b0;
	always @(negedge clock) ph <= !ph;
	initial {port1Data, port2Data} = 20'h00000;
	// each word stands two clocks, so at most one 1x capture takes it
	task automatic send(input int n, input logic [1:0] mode);
		for (int i = 0; i <= n; i++) begin
			@(negedge clock);
			while ((multiplierActive || mode == 2'b11) ? ph : lockOrHalfClockOut)
				@(negedge clock);
			port1Data = (i == n) ? 10'h000 : (i == 0) ? 10'h3ff : 10'($urandom % 32'd1023 + 32'd1);
			port2Data = (i == n) ? 10'h000 : 10'($urandom % 32'd1023 + 32'd1);
			if (i < n && !mode[1]) expQ.push_back(port1Data);
			if (i < n && !mode[0]) expQ.push_back(port2Data);
		end
	endtask : send
endmodule : dpdm_data_source
`default_nettype wire

// ### sim/test_dual_port_dac_input_mux.sv
// self-checking bench for the dac input mux
`default_nettype none
module test_dual_port_dac_input_mux;
	timeunit 1ns;
	timeprecision 1ns;
	logic       clock = 1'b0, reset = 1'b1, multiplierSupplyStrap = 1'b1;
	logic       modeSelectLow = 1'b0, modeSelectHigh = 1'b0, alignReset = 1'b0;
	logic [9:0] port1Data, port2Data, trueCurrentOut, complementCurrentOut, expCode;
	logic       lockOrHalfClockOut, dacUpdate, invalidModeFlag, multiplierActive, live = 1'b0;
	int         fail_count = 0, n_compared = 0;
	dpdm_input_mux #(.LOCK_CYCLES(4)) uut (.clock, .reset, .port1Data, .port2Data,
		.multiplierSupplyStrap, .modeSelectLow, .modeSelectHigh, .alignReset,
		.lockOrHalfClockOut, .trueCurrentOut, .complementCurrentOut, .dacUpdate,
		.invalidModeFlag, .multiplierActive);
	dpdm_data_source src (.clock, .multiplierActive, .lockOrHalfClockOut, .port1Data,
		.port2Data);
	initial forever #25 clock = ~clock;
	task automatic check(input string what, input logic [9:0] exp, input logic [9:0] got);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic check_bit(input string what, input logic exp, input logic got);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %b seen %b", what, exp, got);
		end
	endtask : check_bit
	task automatic finish_test();
		if (fail_count == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : finish_test
	// leading zeros are the latches' stale contents (reset or the last send's zero word), not stream words
	always @(negedge clock) begin
		if (!reset && dacUpdate === 1'b1) begin
			if (src.expQ.size() == 0) check("idle code", 10'h000, trueCurrentOut);
			else if (live || trueCurrentOut !== 10'h000) begin
				live = 1'b1;
				expCode = src.expQ.pop_front();
				check("true code", expCode, trueCurrentOut);
				check("complement", 10'h3ff - expCode, complementCurrentOut);
				live = src.expQ.size() != 0;
			end
		end
	end
	initial begin
		#150000;
		fail_count++;
		finish_test();
	end
	initial begin
		void'($urandom(32'h3d96));
		repeat (2) @(negedge clock);
		reset = 1'b0;
		repeat (14) @(negedge clock);
		check_bit("lock pin", 1'b1, lockOrHalfClockOut);
		check_bit("multiplier on", 1'b1, multiplierActive);
		src.send(6, 2'b00);
		repeat (8) @(negedge clock);
		multiplierSupplyStrap = 1'b0;
		repeat (8) @(negedge clock);
		check_bit("multiplier off", 1'b0, multiplierActive);
		alignReset = 1'b1;
		repeat (6) @(negedge clock);
		check_bit("align pin", 1'b1, lockOrHalfClockOut);
		alignReset = 1'b0;
		repeat (8) @(negedge clock);
		for (int m = 0; m < 4; m++) begin
			{modeSelectHigh, modeSelectLow} = 2'(m);
			repeat (6) @(negedge clock);
			check_bit("invalid flag", m == 3, invalidModeFlag);
			src.send(6, 2'(m));
			repeat (8) @(negedge clock);
		end
		check("pending words", 10'h000, 10'(src.expQ.size()));
		finish_test();
	end
endmodule : test_dual_port_dac_input_mux
`default_nettype wire
